// File: oscsel_pkg.sv
// Package with the register map, field layout and decode codes of the oscillator selector.
package oscsel_pkg;
    // Register byte offsets on the Avalon-MM bus.
    localparam logic [3:0] OSCSEL_OFS_CLOCK_CONTROL = 4'h0;
    localparam logic [3:0] OSCSEL_OFS_FRC_TRIM      = 4'h4;
    localparam logic [3:0] OSCSEL_OFS_STATUS        = 4'h8;
    // Clock control register field positions.
    localparam int OSCSEL_POS_CURRENT_GROUP = 12;
    localparam int OSCSEL_POS_NEW_GROUP     = 8;
    localparam int OSCSEL_POS_LOCK          = 5;
    localparam int OSCSEL_POS_KEEP_ON       = 1;
    // Status register field positions.
    localparam int OSCSEL_POS_RELEASED      = 0;
    localparam int OSCSEL_POS_LOW_POWER_INTERNAL_RC_ON       = 1;
    localparam int OSCSEL_POS_PLL_ON        = 2;
    localparam int OSCSEL_POS_RATIO         = 4;
    localparam int OSCSEL_POS_PIN2          = 8;
    // Reset values.
    localparam logic [3:0] OSCSEL_RST_TRIM      = 4'h0;
    localparam logic       OSCSEL_RST_KEEP_ON   = 1'b0;
    localparam logic [2:0] OSCSEL_RST_GROUP     = 3'h0;
    // Start-up counter width and terminal count.
    localparam int OSCSEL_STARTUP_BITS = 10;
    localparam logic [9:0] OSCSEL_STARTUP_LAST = 10'h3FF;
    // Oscillator groups.
    typedef enum logic [2:0] {
        OSCSEL_GRP_SECONDARY = 3'b000,
        OSCSEL_GRP_FAST_RC   = 3'b001,
        OSCSEL_GRP_LOW_RC    = 3'b010,
        OSCSEL_GRP_PRIMARY   = 3'b011,
        OSCSEL_GRP_PRI_PLL   = 3'b111
    } oscsel_group_t;
    // Multiplier ratio codes.
    typedef enum logic [1:0] {
        OSCSEL_MUL_NONE = 2'b00,
        OSCSEL_MUL_X4   = 2'b01,
        OSCSEL_MUL_X8   = 2'b10,
        OSCSEL_MUL_X16  = 2'b11
    } oscsel_mul_t;
    // Function of the second oscillator pin.
    typedef enum logic [1:0] {
        OSCSEL_PIN2_OSC  = 2'b00,
        OSCSEL_PIN2_INSTR_CLOCK_OUT = 2'b01,
        OSCSEL_PIN2_IO   = 2'b10
    } oscsel_pin2_t;
    // Source that feeds the system clock.
    typedef enum logic [2:0] {
        OSCSEL_SRC_SECONDARY = 3'b000,
        OSCSEL_SRC_FAST_RC   = 3'b001,
        OSCSEL_SRC_LOW_RC    = 3'b010,
        OSCSEL_SRC_CRYSTAL   = 3'b011,
        OSCSEL_SRC_EXT_CLOCK = 3'b100,
        OSCSEL_SRC_EXT_RC    = 3'b101,
        OSCSEL_SRC_NONE      = 3'b111
    } oscsel_src_t;
endpackage

// File: oscsel_top.sv
// Oscillator source selection, start-up counter and register slave.
//
// Decided for this implementation: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps

// Operation
// - 10-bit counter holds crystal for 1024 periods.
// - Count applies on POR/BOR/wake for crystals only.
// - Decode group field into five oscillator groups.
// - Primary-mode field picks source, ratio, pin function.
// - Codes 00001/01010/00011 multiply fast RC.
// - First oscillator pin never becomes general I/O.
// - Secondary oscillator runs whenever keep-on is set.
// - Secondary clocks system only with group 000 and keep-on.
// - Multiplier offers x4, x8 and x16 gains.
// - Lock indication mirrored in read-only clock control bit.
// - Current group 001 runs from fast RC.
// - Four-bit signed trim steers fast RC frequency.
// - Low-power RC clocks timers, selectable as system clock.
// - Low-power RC always enabled at power-on reset.
// - After delay, low-power RC stays on only when needed.
// - POR/BOR load current and new group from configuration.
// - Five groups, twenty-two primary choices.
module oscsel_top
    import oscsel_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic [2:0]  group_select_cfg,
    input  wire logic [4:0]  primary_select_cfg,
    input  wire logic        por_event,
    input  wire logic        bor_event,
    input  wire logic        wake_event,
    input  wire logic        powerup_delay_done,
    input  wire logic        clock_fail_monitor_en,
    input  wire logic        watchdog_en,
    input  wire logic        raw_osc,
    input  wire logic        pll_lock,
    output logic [2:0]       sys_clock_source,
    output logic             sys_clock_released,
    output logic             pll_enable,
    output logic [1:0]       pll_ratio,
    output logic             pll_from_fast_rc,
    output logic [1:0]       osc_out_pin_function,
    output logic             osc_in_pin_io_enable,
    output logic             secondary_osc_enable,
    output logic             fast_rc_enable,
    output logic [3:0]       frc_trim,
    output logic             low_rc_enable
);
    // Register state.
    logic [2:0]  current_group;
    logic [2:0]  new_group;
    logic        secondary_keep_on;
    logic        load_pending;
    logic        ack;
    logic [2:0]  next_current_group;
    logic [2:0]  next_new_group;
    logic        next_secondary_keep_on;
    logic [3:0]  next_frc_trim;
    logic        next_load_pending;
    logic        next_ack;
    logic [31:0] next_readdata;
    // Start-up state.
    logic [OSCSEL_STARTUP_BITS-1:0] startup_counter;
    logic [OSCSEL_STARTUP_BITS-1:0] next_startup_counter;
    logic        raw_osc_q;
    logic        startup_done;
    logic        next_startup_done;
    logic        powered_up;
    logic        next_powered_up;
    // Decoded selection.
    oscsel_mul_t  mul;
    oscsel_pin2_t pin2;
    oscsel_src_t  pri_src;
    logic         pri_is_crystal;
    logic         pri_uses_frc;
    logic         sel_is_crystal;
    logic [2:0]   restart_group;
    logic         restart;
    logic         wr_ok;
    logic         rd_ok;
    logic [31:0]  ctrl_word;
    logic [31:0]  stat_word;

    // Primary-mode decode: source type, multiplier ratio and second pin use.
    always_comb begin
        mul            = OSCSEL_MUL_NONE;
        pin2           = OSCSEL_PIN2_OSC;
        pri_src        = OSCSEL_SRC_NONE;
        pri_is_crystal = 1'b0;
        pri_uses_frc   = 1'b0;
        unique case (primary_select_cfg)
            5'h0D, 5'h0E, 5'h0F: begin
                pri_src = OSCSEL_SRC_EXT_CLOCK;
                pin2    = OSCSEL_PIN2_IO;
                mul     = oscsel_mul_t'(primary_select_cfg[1:0] - 2'b00);
            end
            5'h01, 5'h0A, 5'h03: begin
                pri_src      = OSCSEL_SRC_FAST_RC;
                pin2         = OSCSEL_PIN2_IO;
                pri_uses_frc = 1'b1;
                mul          = (primary_select_cfg == 5'h01) ? OSCSEL_MUL_X4 :
                               (primary_select_cfg == 5'h0A) ? OSCSEL_MUL_X8 : OSCSEL_MUL_X16;
            end
            5'h05, 5'h06, 5'h07, 5'h11, 5'h12, 5'h13, 5'h15, 5'h16, 5'h17: begin
                pri_src        = OSCSEL_SRC_CRYSTAL;
                pri_is_crystal = 1'b1;
                mul            = (primary_select_cfg[1:0] == 2'b01) ? OSCSEL_MUL_X4 :
                                 (primary_select_cfg[1:0] == 2'b10) ? OSCSEL_MUL_X8 :
                                 OSCSEL_MUL_X16;
            end
            5'h0C: begin
                pri_src = OSCSEL_SRC_EXT_CLOCK;
                pin2    = OSCSEL_PIN2_IO;
            end
            5'h04, 5'h02, 5'h00: begin
                pri_src        = OSCSEL_SRC_CRYSTAL;
                pri_is_crystal = 1'b1;
            end
            5'h0B: begin
                pri_src = OSCSEL_SRC_EXT_CLOCK;
                pin2    = OSCSEL_PIN2_INSTR_CLOCK_OUT;
            end
            5'h09: begin
                pri_src = OSCSEL_SRC_EXT_RC;
                pin2    = OSCSEL_PIN2_INSTR_CLOCK_OUT;
            end
            5'h08: begin
                pri_src = OSCSEL_SRC_EXT_RC;
                pin2    = OSCSEL_PIN2_IO;
            end
            default: begin
                pri_src = OSCSEL_SRC_NONE;
                pin2    = OSCSEL_PIN2_IO;
            end
        endcase
    end

    // Group decode drives the clock source, multiplier and oscillator enables.
    always_comb begin
        sys_clock_source = OSCSEL_SRC_NONE;
        pll_enable       = 1'b0;
        pll_ratio        = OSCSEL_MUL_NONE;
        pll_from_fast_rc = 1'b0;
        fast_rc_enable   = 1'b0;
        unique case (current_group)
            OSCSEL_GRP_PRI_PLL: begin
                sys_clock_source = pri_src;
                pll_enable       = (mul != OSCSEL_MUL_NONE);
                pll_ratio        = mul;
                pll_from_fast_rc = pri_uses_frc;
                fast_rc_enable   = pri_uses_frc;
            end
            OSCSEL_GRP_PRIMARY: begin
                sys_clock_source = (mul == OSCSEL_MUL_NONE) ? pri_src : OSCSEL_SRC_NONE;
            end
            OSCSEL_GRP_SECONDARY: begin
                sys_clock_source = secondary_keep_on ? OSCSEL_SRC_SECONDARY
                                                     : OSCSEL_SRC_NONE;
            end
            OSCSEL_GRP_FAST_RC: begin
                sys_clock_source = OSCSEL_SRC_FAST_RC;
                fast_rc_enable   = 1'b1;
            end
            OSCSEL_GRP_LOW_RC: begin
                sys_clock_source = OSCSEL_SRC_LOW_RC;
            end
            default: begin
                sys_clock_source = OSCSEL_SRC_NONE;
            end
        endcase
    end

    // Restart judgement. A power-on or brown-out restart looks at the group that it is
    // about to load, so a new configuration decides whether the crystal is counted in.
    always_comb begin
        restart_group  = (por_event || bor_event) ? group_select_cfg : current_group;
        sel_is_crystal = 1'b0;
        unique case (restart_group)
            OSCSEL_GRP_PRI_PLL: begin
                sel_is_crystal = pri_is_crystal;
            end
            OSCSEL_GRP_PRIMARY: begin
                sel_is_crystal = pri_is_crystal && (mul == OSCSEL_MUL_NONE);
            end
            OSCSEL_GRP_SECONDARY: begin
                sel_is_crystal = 1'b1;
            end
            default: begin
                sel_is_crystal = 1'b0;
            end
        endcase
    end

    // Pin and oscillator enables that follow directly from the selection.
    assign osc_out_pin_function = (current_group == OSCSEL_GRP_PRI_PLL ||
                                   current_group == OSCSEL_GRP_PRIMARY) ? pin2 : OSCSEL_PIN2_IO;
    assign osc_in_pin_io_enable = 1'b0;
    assign secondary_osc_enable = secondary_keep_on;
    assign low_rc_enable        = !powered_up || clock_fail_monitor_en || watchdog_en ||
                                  (current_group == OSCSEL_GRP_LOW_RC);
    assign sys_clock_released   = startup_done && (sys_clock_source != OSCSEL_SRC_NONE);
    assign restart              = por_event || bor_event || wake_event;

    // Start-up counter: cleared on restart, counts rising raw oscillator edges.
    always_comb begin
        next_startup_counter = startup_counter;
        next_startup_done    = startup_done;
        next_powered_up      = powered_up;
        if (powerup_delay_done) begin
            next_powered_up = 1'b1;
        end
        if (por_event) begin
            next_powered_up = 1'b0;
        end
        if (restart) begin
            next_startup_counter = '0;
            next_startup_done    = !sel_is_crystal;
        end else if (!startup_done && raw_osc && !raw_osc_q) begin
            next_startup_counter = startup_counter + 1'b1;
            if (startup_counter == OSCSEL_STARTUP_LAST) begin
                next_startup_done = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            startup_counter <= '0;
            startup_done    <= 1'b0;
            powered_up      <= 1'b0;
            raw_osc_q       <= 1'b0;
        end else begin
            startup_counter <= next_startup_counter;
            startup_done    <= next_startup_done;
            powered_up      <= next_powered_up;
            raw_osc_q       <= raw_osc;
        end
    end

    // Register read words.
    always_comb begin
        ctrl_word = 32'h0;
        ctrl_word[OSCSEL_POS_CURRENT_GROUP +: 3] = current_group;
        ctrl_word[OSCSEL_POS_NEW_GROUP +: 3]     = new_group;
        ctrl_word[OSCSEL_POS_LOCK]               = pll_lock;
        ctrl_word[OSCSEL_POS_KEEP_ON]            = secondary_keep_on;
        stat_word = 32'h0;
        stat_word[OSCSEL_POS_RELEASED]  = sys_clock_released;
        stat_word[OSCSEL_POS_LOW_POWER_INTERNAL_RC_ON]   = low_rc_enable;
        stat_word[OSCSEL_POS_PLL_ON]    = pll_enable;
        stat_word[OSCSEL_POS_RATIO +: 2] = pll_ratio;
        stat_word[OSCSEL_POS_PIN2 +: 2]  = osc_out_pin_function;
    end

    // Avalon slave: one wait cycle, write data takes effect with waitrequest low, read data is captured in the wait cycle.
    assign avs_waitrequest = (avs_read || avs_write) && !ack;
    assign wr_ok = avs_write && ack;
    assign rd_ok = avs_read && !ack;

    always_comb begin
        next_ack               = (avs_read || avs_write) && !ack;
        next_readdata          = avs_readdata;
        next_current_group     = current_group;
        next_new_group         = new_group;
        next_secondary_keep_on = secondary_keep_on;
        next_frc_trim          = frc_trim;
        next_load_pending      = 1'b0;
        if (rd_ok) begin
            unique case (avs_address)
                OSCSEL_OFS_CLOCK_CONTROL: next_readdata = ctrl_word;
                OSCSEL_OFS_FRC_TRIM:      next_readdata = {28'h0, frc_trim};
                OSCSEL_OFS_STATUS:        next_readdata = stat_word;
                default:                  next_readdata = 32'h0;
            endcase
        end
        if (wr_ok) begin
            unique case (avs_address)
                OSCSEL_OFS_CLOCK_CONTROL: begin
                    next_new_group         = avs_writedata[OSCSEL_POS_NEW_GROUP +: 3];
                    next_secondary_keep_on = avs_writedata[OSCSEL_POS_KEEP_ON];
                end
                OSCSEL_OFS_FRC_TRIM: begin
                    next_frc_trim = avs_writedata[3:0];
                end
                default: begin
                    next_frc_trim = frc_trim;
                end
            endcase
        end
        // Configuration load on power-on, brown-out and the first cycle after reset.
        if (load_pending || por_event || bor_event) begin
            next_current_group = group_select_cfg;
            next_new_group     = group_select_cfg;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ack               <= 1'b0;
            avs_readdata      <= 32'h0;
            current_group     <= OSCSEL_RST_GROUP;
            new_group         <= OSCSEL_RST_GROUP;
            secondary_keep_on <= OSCSEL_RST_KEEP_ON;
            frc_trim          <= OSCSEL_RST_TRIM;
            load_pending      <= 1'b1;
        end else begin
            ack               <= next_ack;
            avs_readdata      <= next_readdata;
            current_group     <= next_current_group;
            new_group         <= next_new_group;
            secondary_keep_on <= next_secondary_keep_on;
            frc_trim          <= next_frc_trim;
            load_pending      <= next_load_pending;
        end
    end
endmodule

// File: oscsel_osc_model.sv
// Behavioural crystal and frequency multiplier facing the oscillator selector.
`timescale 1ns/1ps
module oscsel_osc_model (
    input  wire logic clk,
    input  wire logic run,
    input  wire logic lose,
    input  wire logic pll_enable,
    output logic      raw_osc,
    output logic      pll_lock
);
    logic [1:0] ph = 2'h0;
    logic [3:0] lk = 4'h0;
    logic       osc = 1'b0;
    // The crystal toggles every two cycles while running and rests low when stopped.
    always @(posedge clk) begin
        ph  <= run ? ph + 2'h1 : 2'h0;
        osc <= run & ph[1];
    end
    assign raw_osc = osc;
    // Lock comes fifteen cycles after enable and drops at once on a disturbance.
    always @(posedge clk) begin
        lk <= (pll_enable && !lose) ? lk + {3'h0, lk != 4'hF} : 4'h0;
    end
    assign pll_lock = (lk == 4'hF);
endmodule

// File: oscsel_top_asserts.sv
// Concurrent checks on the ports of the oscillator selector.
`timescale 1ns/1ps
module oscsel_top_asserts
    import oscsel_pkg::*;
(
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic [3:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic [4:0]  primary_select_cfg,
    input wire logic        por_event,
    input wire logic        bor_event,
    input wire logic        wake_event,
    input wire logic        clock_fail_monitor_en,
    input wire logic        watchdog_en,
    input wire logic        raw_osc,
    input wire logic        pll_lock,
    input wire logic [2:0]  sys_clock_source,
    input wire logic        sys_clock_released,
    input wire logic [1:0]  pll_ratio,
    input wire logic        pll_from_fast_rc,
    input wire logic        osc_in_pin_io_enable,
    input wire logic        secondary_osc_enable,
    input wire logic        fast_rc_enable,
    input wire logic        low_rc_enable
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    logic        osc_q;
    logic        wd_keep;
    logic [10:0] edge_cnt;
    assign wd_keep = avs_writedata[OSCSEL_POS_KEEP_ON];
    // Counts sampled oscillator rising edges since the last restart event.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            osc_q    <= 1'b0;
            edge_cnt <= 11'h000;
        end else begin
            osc_q <= raw_osc;
            if (por_event || bor_event || wake_event)
                edge_cnt <= 11'h000;
            else if (raw_osc && !osc_q && edge_cnt != 11'h7FF)
                edge_cnt <= edge_cnt + 11'h001;
        end
    end
    xtal_hold_a: assert property (sys_clock_source == OSCSEL_SRC_CRYSTAL &&
        $rose(sys_clock_released) |-> edge_cnt == 11'h400) else $error("crystal released early");
    bus_wait_a: assert property ($rose(avs_read || avs_write) |->
        avs_waitrequest ##1 !avs_waitrequest) else $error("wait cycle count wrong");
    in_pin_a: assert property (osc_in_pin_io_enable == 1'b0)
        else $error("first oscillator pin released");
    keep_on_a: assert property (avs_write && !avs_waitrequest &&
        avs_address == OSCSEL_OFS_CLOCK_CONTROL |=> secondary_osc_enable == $past(wd_keep))
        else $error("keep-on not written");
    sec_src_a: assert property (sys_clock_source == OSCSEL_SRC_SECONDARY |->
        secondary_osc_enable) else $error("secondary clock without keep-on");
    pll_ratio_a: assert property (pll_from_fast_rc |->
        (primary_select_cfg == 5'h01 && pll_ratio == OSCSEL_MUL_X4) ||
        (primary_select_cfg == 5'h0A && pll_ratio == OSCSEL_MUL_X8) ||
        (primary_select_cfg == 5'h03 && pll_ratio == OSCSEL_MUL_X16)) else $error("ratio wrong");
    fast_rc_a: assert property (sys_clock_source == OSCSEL_SRC_FAST_RC |-> fast_rc_enable)
        else $error("fast oscillator off while selected");
    low_rc_a: assert property (!low_rc_enable |-> !clock_fail_monitor_en && !watchdog_en &&
        sys_clock_source != OSCSEL_SRC_LOW_RC) else $error("low oscillator off while needed");
    por_low_power_internal_rc_a: assert property (por_event |=> low_rc_enable)
        else $error("low oscillator off after power-on");
    lock_read_a: assert property (avs_read && !avs_waitrequest &&
        avs_address == OSCSEL_OFS_CLOCK_CONTROL |-> avs_readdata[OSCSEL_POS_LOCK] == $past(pll_lock))
        else $error("lock bit not mirrored");
endmodule
bind oscsel_top oscsel_top_asserts u_asserts (
    .clk, .arst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .primary_select_cfg, .por_event, .bor_event, .wake_event,
    .clock_fail_monitor_en, .watchdog_en, .raw_osc, .pll_lock, .sys_clock_source,
    .sys_clock_released, .pll_ratio, .pll_from_fast_rc, .osc_in_pin_io_enable,
    .secondary_osc_enable, .fast_rc_enable, .low_rc_enable
);

// File: oscsel_top_tb.sv
// Self-checking testbench for the oscillator selector and its register slave.
`timescale 1ns/1ps
module oscsel_top_tb
    import oscsel_pkg::*;
;
    logic        clk = 1'b0, arst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, run = 1'b0;
    logic        por_event = 1'b0, bor_event = 1'b0, wake_event = 1'b0, lose = 1'b0;
    logic        powerup_delay_done = 1'b0, clock_fail_monitor_en = 1'b0, watchdog_en = 1'b0;
    logic [3:0]  avs_address = 4'h0, frc_trim;
    logic [31:0] avs_writedata = 32'h0, lfsr = 32'hDC513230, m, avs_readdata, exp_q[$], msk_q[$];
    logic [2:0]  group_select_cfg = 3'h3, sys_clock_source;
    logic [4:0]  primary_select_cfg = 5'h04;
    logic [15:0] t;
    logic        avs_waitrequest, sys_clock_released, pll_enable, pll_from_fast_rc, pll_lock;
    logic        osc_in_pin_io_enable, secondary_osc_enable, fast_rc_enable, low_rc_enable, raw_osc;
    logic [1:0]  pll_ratio, osc_out_pin_function;
    int          num_errors = 0, cmp_count = 0;
    // Group, mode, source, multiplier on, ratio, second pin function (3 means unchecked).
    logic [15:0] dec_tab [15] = '{16'hE1F6, 16'hEAFA, 16'hE3FE, 16'hE5F4, 16'hF7FC, 16'hEDF6,
        16'h6460, 16'h6260, 16'h6060, 16'h6B81, 16'h6C82, 16'h69A1, 16'h68A2, 16'h2023, 16'h4043};
    always #2.5 clk = ~clk;
    oscsel_top u_dut (
        .clk, .arst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
        .avs_waitrequest, .group_select_cfg, .primary_select_cfg, .por_event, .bor_event,
        .wake_event, .powerup_delay_done, .clock_fail_monitor_en, .watchdog_en, .raw_osc,
        .pll_lock, .sys_clock_source, .sys_clock_released, .pll_enable, .pll_ratio,
        .pll_from_fast_rc, .osc_out_pin_function, .osc_in_pin_io_enable,
        .secondary_osc_enable, .fast_rc_enable, .frc_trim, .low_rc_enable
    );
    oscsel_osc_model u_osc (.clk, .run, .lose, .pll_enable, .raw_osc, .pll_lock);
    // Shared comparison that counts every check.
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
        cmp_count++;
        if (s !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, e, s);
        end
    endtask
    // Steps the stimulus shift register by one place.
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic finish_test();
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // One bus transfer held until waitrequest is sampled low.
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        avs_write     <= w;
        avs_read      <= !w;
        avs_address   <= a;
        avs_writedata <= d;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) @(posedge clk);
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] mk);
        exp_q.push_back(e & mk);
        msk_q.push_back(mk);
        bus(1'b0, a, 32'h0);
    endtask
    // Restart pulse: bit 2 power-on, bit 1 brown-out, bit 0 wake.
    task automatic evt(input logic [2:0] k);
        {por_event, bor_event, wake_event} <= k;
        @(posedge clk);
        {por_event, bor_event, wake_event} <= 3'b000;
        @(posedge clk);
    endtask
    task automatic cfg(input logic [2:0] g, input logic [4:0] p);
        group_select_cfg   <= g;
        primary_select_cfg <= p;
        evt(3'b010);
    endtask
    // Takes the oldest expectation whenever read data is answered.
    always @(posedge clk) begin
        if (avs_read && avs_waitrequest === 1'b0) begin
            chk("readdata", exp_q.pop_front(), avs_readdata & msk_q.pop_front());
        end
    end
    // Cuts a hang short.
    initial begin
        repeat (40000) @(posedge clk);
        num_errors++;
        finish_test();
    end
    // Main sequence.
    initial begin
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge clk);
        chk("low_rc", 32'(1), 32'(low_rc_enable));
        rd(OSCSEL_OFS_CLOCK_CONTROL, 32'h3300, 32'h7722);
        rd(OSCSEL_OFS_FRC_TRIM, 32'h0, 32'hF);
        evt(3'b100);
        chk("released", 32'(0), 32'(sys_clock_released));
        run <= 1'b1;
        repeat (4000) @(posedge clk);
        chk("released", 32'(0), 32'(sys_clock_released));
        for (int n = 0; n < 300 && !sys_clock_released; n++) @(posedge clk);
        rd(OSCSEL_OFS_STATUS, 32'h1, 32'h1);
        run <= 1'b0;
        evt(3'b001);
        chk("released", 32'(0), 32'(sys_clock_released));
        foreach (dec_tab[i]) begin
            t = dec_tab[i];
            cfg(t[15:13], t[12:8]);
            if (t[15:13] != 3'b111)
                chk("source", 32'(t[7:5]), 32'(sys_clock_source));
            if (t[15:13] != 3'b011 && t[15:13] != 3'b111)
                chk("released", 32'(1), 32'(sys_clock_released));
            chk("from_fast", 32'(t[15:13] == 3'b111 && t[12:8] inside {5'h01, 5'h0A, 5'h03}),
                32'(pll_from_fast_rc));
            rd(OSCSEL_OFS_STATUS, {22'h0, t[1:0], 2'b00, t[3:2], 1'b0, t[4], 2'b00},
                (t[1:0] == 2'b11) ? 32'h034 : 32'h334);
            rd(OSCSEL_OFS_CLOCK_CONTROL, {17'h0, t[15:13], 1'b0, t[15:13], 8'h0}, 32'h7700);
        end
        cfg(3'b111, 5'h01);
        repeat (20) @(posedge clk);
        rd(OSCSEL_OFS_CLOCK_CONTROL, 32'h20, 32'h20);
        lose <= 1'b1;
        repeat (3) @(posedge clk);
        rd(OSCSEL_OFS_CLOCK_CONTROL, 32'h0, 32'h20);
        lose <= 1'b0;
        cfg(3'b000, 5'h04);
        chk("no_keep", 32'(1), 32'(sys_clock_source !== OSCSEL_SRC_SECONDARY));
        bus(1'b1, OSCSEL_OFS_CLOCK_CONTROL, 32'hFFFFFAFF);
        rd(OSCSEL_OFS_CLOCK_CONTROL, 32'h0202, 32'h7702);
        chk("keep_on", 32'(1), 32'(secondary_osc_enable));
        chk("source", 32'(OSCSEL_SRC_SECONDARY), 32'(sys_clock_source));
        bus(1'b1, 4'hC, lfsr);
        rd(4'hC, 32'h0, 32'hFFFFFFFF);
        for (int i = 0; i < 6; i++) begin
            lfsr = lfsr_next(lfsr);
            m = {lfsr[31:4], (i == 0) ? 4'h7 : (i == 1) ? 4'h8 : (i == 2) ? 4'hF : lfsr[3:0]};
            bus(1'b1, OSCSEL_OFS_FRC_TRIM, m);
            rd(OSCSEL_OFS_FRC_TRIM, m, 32'hF);
            chk("trim", 32'(m[3:0]), 32'(frc_trim));
        end
        cfg(3'b001, 5'h04);
        powerup_delay_done <= 1'b1;
        @(posedge clk);
        powerup_delay_done <= 1'b0;
        @(posedge clk);
        chk("low_rc", 32'(0), 32'(low_rc_enable));
        watchdog_en <= 1'b1;
        @(posedge clk);
        chk("low_rc", 32'(1), 32'(low_rc_enable));
        watchdog_en           <= 1'b0;
        clock_fail_monitor_en <= 1'b1;
        @(posedge clk);
        chk("low_rc", 32'(1), 32'(low_rc_enable));
        clock_fail_monitor_en <= 1'b0;
        cfg(3'b010, 5'h04);
        chk("low_rc", 32'(1), 32'(low_rc_enable));
        // Power-on into the fast group, so only the re-armed delay keeps the low oscillator on.
        group_select_cfg <= 3'b001;
        evt(3'b100);
        chk("low_rc", 32'(1), 32'(low_rc_enable));
        repeat (2) @(posedge clk);
        finish_test();
    end
endmodule
